// [tlas_field_model.sv]
// Analog field sources: voltage input, current transmitter and keypad pot
`timescale 1ns/10ps
module tlas_field_model (
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rstn,
    // New levels from the bench
    input  wire logic       i_load,
    input  wire logic [9:0] i_vin,
    input  wire logic [9:0] i_iin,
    input  wire logic [9:0] i_pot,
    // Levels at the analog terminals
    output logic      [9:0] o_vin,
    output logic      [9:0] o_iin,
    output logic      [9:0] o_pot
);
    // Levels settle one cycle after a load, like a slow transmitter; never negative
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_vin <= 10'h000;
            o_iin <= 10'h000;
            o_pot <= 10'h000;
        end else if (i_load) begin
            o_vin <= i_vin;
            o_iin <= i_iin;
            o_pot <= i_pot;
        end
    end
endmodule : tlas_field_model

// [tlas_mon_scale.sv]
// Monitor output scaler: offset plus gain-scaled fraction, saturated
`timescale 1ns/10ps
module tlas_mon_scale (
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rstn,
    // Quantity and settings
    input  wire logic [9:0] i_quantity,
    input  wire logic [7:0] i_gain,
    input  wire logic [9:0] i_offset,
    // Scaled level
    output logic      [9:0] o_level
);
    logic [21:0] prod;
    logic [21:0] frac;
    logic [11:0] sum;
    logic [9:0]  nxt_level;
    logic [9:0]  level_ff;

    // Gain 100 maps a full-scale quantity onto the full 10 V span
    assign prod = 22'(i_quantity) * 22'(i_gain) * tlas_pkg::MON_SCALE;
    assign frac = prod / tlas_pkg::IN_FS_W;
    assign sum  = frac[11:0] + 12'(i_offset);
    // Saturate; unsigned math keeps it non-negative in either direction
    assign nxt_level = (sum > 12'(tlas_pkg::MON_FS)) ? tlas_pkg::MON_FS
                                                       : sum[9:0];

    // Registered so the top output comes straight from a flip-flop
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            level_ff <= 10'h000;
        end else begin
            level_ff <= nxt_level;
        end
    end

    assign o_level = level_ff;
endmodule : tlas_mon_scale

// [tlas_pkg.sv]
// Constants for the terminal logic and analog select block
package tlas_pkg;
    // Gate operator codes
    localparam logic [1:0] OP_AND       = 2'h0;
    localparam logic [1:0] OP_OR        = 2'h1;
    localparam logic [1:0] OP_XOR       = 2'h2;
    // Internal output conditions usable as gate operands
    localparam int         NUM_COND     = 9;
    localparam int         NUM_TERM     = 3;
    localparam logic [3:0] FUNC_LOG     = 4'h9;
    // Frequency source select code for the analog inputs
    localparam logic [1:0] SRC_ANALOG   = 2'h1;
    // Analog configuration codes
    localparam logic [1:0] CFG_VI       = 2'h0;
    localparam logic [1:0] CFG_SUM      = 2'h1;
    localparam logic [1:0] CFG_VPOT     = 2'h2;
    localparam logic [1:0] CFG_IPOT     = 2'h3;
    // Monitor quantity codes
    localparam logic [1:0] QTY_FREQ     = 2'h0;
    localparam logic [1:0] QTY_CURR     = 2'h1;
    // Monitor level: 0..1000 is 0..10.00 V in 10 mV steps
    localparam logic [9:0]  MON_FS      = 10'h3E8;
    localparam logic [9:0]  IN_FS       = 10'h3FF;
    localparam logic [7:0]  GAIN_RST    = 8'h64;
    localparam logic [9:0]  OFFSET_RST  = 10'h000;
    // Full-scale level divided by unity gain (1000 / 100)
    localparam logic [21:0] MON_SCALE   = 22'h00000A;
    localparam logic [21:0] IN_FS_W     = 22'h0003FF;
endpackage : tlas_pkg

// [tlas_top.sv]
// Terminal logic gate, analog frequency command select and analog monitor
`timescale 1ns/10ps
module tlas_top (
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rstn,
    // Logic gate configuration and conditions
    input  wire logic [8:0]  i_out_cond,
    input  wire logic [3:0]  i_operand_a_select,
    input  wire logic [3:0]  i_operand_b_select,
    input  wire logic [1:0]  i_gate_operator_select,
    // Output terminal function codes
    input  wire logic [3:0]  i_term11_func,
    input  wire logic [3:0]  i_term12_func,
    input  wire logic [3:0]  i_relay_func,
    // Analog input selection
    input  wire logic        i_input_kind_sel,
    input  wire logic        i_kind_sel_assigned,
    input  wire logic [1:0]  i_frequency_source_select,
    input  wire logic [1:0]  i_analog_input_config,
    input  wire logic [9:0]  i_vin_sense,
    input  wire logic [9:0]  i_iin_sense,
    input  wire logic [9:0]  i_keypad_pot,
    // Monitor configuration and quantities
    input  wire logic [1:0]  i_monitor_quantity_select,
    input  wire logic [9:0]  i_out_freq,
    input  wire logic [9:0]  i_out_current,
    input  wire logic        i_monitor_gain_wr,
    input  wire logic [7:0]  i_monitor_gain,
    input  wire logic        i_monitor_offset_wr,
    input  wire logic [9:0]  i_monitor_offset,
    // Terminal outputs
    output logic             o_gate_result,
    output logic             o_term11,
    output logic             o_term12,
    output logic             o_relay,
    // Frequency command
    output logic             o_freq_cmd_valid,
    output logic      [10:0] o_freq_cmd,
    // Monitor settings and level
    output logic      [7:0]  o_monitor_gain,
    output logic      [9:0]  o_monitor_offset,
    output logic      [9:0]  o_monitor_output
);
    logic              opnd_a;
    logic              opnd_b;
    logic              gate_now;
    logic [3:0]        term_func [tlas_pkg::NUM_TERM];
    logic [tlas_pkg::NUM_TERM-1:0] nxt_term;
    logic [tlas_pkg::NUM_TERM-1:0] term_ff;
    logic              gate_ff;
    logic [10:0]       v_w;
    logic [10:0]       i_w;
    logic [10:0]       pot_w;
    logic [10:0]       sum_w;
    logic [10:0]       cfg_sel;
    logic [10:0]       nxt_freq_cmd;
    logic              nxt_freq_valid;
    logic [10:0]       freq_cmd_ff;
    logic              freq_valid_ff;
    logic [9:0]        mon_qty;
    logic [7:0]        gain_ff;
    logic [9:0]        offset_ff;
    logic [9:0]        nxt_offset;

    // Operand selection; a code above eight reads as a false condition
    assign opnd_a = (i_operand_a_select < 4'(tlas_pkg::NUM_COND))
                    ? i_out_cond[i_operand_a_select] : 1'b0;
    assign opnd_b = (i_operand_b_select < 4'(tlas_pkg::NUM_COND))
                    ? i_out_cond[i_operand_b_select] : 1'b0;

    // Boolean operator; the unused code gives a steady 0
    assign gate_now = (i_gate_operator_select == tlas_pkg::OP_AND) ? (opnd_a & opnd_b)
                    : (i_gate_operator_select == tlas_pkg::OP_OR)  ? (opnd_a | opnd_b)
                    : (i_gate_operator_select == tlas_pkg::OP_XOR) ? (opnd_a ^ opnd_b)
                    : 1'b0;

    assign term_func[0] = i_term11_func;
    assign term_func[1] = i_term12_func;
    assign term_func[2] = i_relay_func;

    // Each terminal shows the gate for code 09, the chosen condition for codes below 9, else 0
    for (genvar t = 0; t < tlas_pkg::NUM_TERM; t++) begin : g_term
        assign nxt_term[t] = (term_func[t] == tlas_pkg::FUNC_LOG) ? gate_now
                           : (term_func[t] < 4'(tlas_pkg::NUM_COND))
                             ? i_out_cond[term_func[t]] : 1'b0;
    end

    // Gate and terminal registers
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            gate_ff <= 1'b0;
            term_ff <= '0;
        end else begin
            gate_ff <= gate_now;
            term_ff <= nxt_term;
        end
    end

    // Analog input widening so the sum cannot overflow
    assign v_w   = 11'(i_vin_sense);
    assign i_w   = 11'(i_iin_sense);
    assign pot_w = 11'(i_keypad_pot);
    assign sum_w = v_w + i_w;

    // Configuration decode; with no kind-select terminal the inputs always sum
    assign cfg_sel = !i_kind_sel_assigned ? sum_w
        : (i_analog_input_config == tlas_pkg::CFG_SUM)  ? sum_w
        : (i_analog_input_config == tlas_pkg::CFG_VI)   ? (i_input_kind_sel ? i_w
                                                                             : v_w)
        : (i_analog_input_config == tlas_pkg::CFG_VPOT) ? (i_input_kind_sel ? pot_w
                                                                             : v_w)
        : (i_input_kind_sel ? pot_w : i_w);

    // Analog inputs command frequency only when they are the chosen source
    assign nxt_freq_valid = (i_frequency_source_select == tlas_pkg::SRC_ANALOG);
    assign nxt_freq_cmd   = nxt_freq_valid ? cfg_sel : 11'h000;

    // Frequency command registers
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            freq_cmd_ff   <= 11'h000;
            freq_valid_ff <= 1'b0;
        end else begin
            freq_cmd_ff   <= nxt_freq_cmd;
            freq_valid_ff <= nxt_freq_valid;
        end
    end

    // Monitor quantity; unused codes drive only the offset level
    assign mon_qty = (i_monitor_quantity_select == tlas_pkg::QTY_FREQ) ? i_out_freq
                   : (i_monitor_quantity_select == tlas_pkg::QTY_CURR) ? i_out_current
                   : 10'h000;

    // Offset writes above 10 V clamp rather than wrap
    assign nxt_offset = (i_monitor_offset > tlas_pkg::MON_FS) ? tlas_pkg::MON_FS
                                                              : i_monitor_offset;

    // Gain and offset settings with their initial values
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            gain_ff   <= tlas_pkg::GAIN_RST;
            offset_ff <= tlas_pkg::OFFSET_RST;
        end else begin
            if (i_monitor_gain_wr) begin
                gain_ff <= i_monitor_gain;
            end
            if (i_monitor_offset_wr) begin
                offset_ff <= nxt_offset;
            end
        end
    end

    // Scaler output is its own register
    tlas_mon_scale u_scale (
        .i_sys_clk  (i_sys_clk),
        .i_rstn     (i_rstn),
        .i_quantity (mon_qty),
        .i_gain     (gain_ff),
        .i_offset   (offset_ff),
        .o_level    (o_monitor_output)
    );

    assign o_gate_result    = gate_ff;
    assign o_term11         = term_ff[0];
    assign o_term12         = term_ff[1];
    assign o_relay          = term_ff[2];
    assign o_freq_cmd       = freq_cmd_ff;
    assign o_freq_cmd_valid = freq_valid_ff;
    assign o_monitor_gain   = gain_ff;
    assign o_monitor_offset = offset_ff;

    // Checks on the gate, command select and monitor
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    gate_xor_a: assert property ((i_gate_operator_select == tlas_pkg::OP_XOR)
        |=> o_gate_result == ($past(opnd_a) ^ $past(opnd_b)))
        else $error("xor gate result wrong");
    gate_and_a: assert property ((i_gate_operator_select == tlas_pkg::OP_AND)
        && !opnd_a |=> !o_gate_result)
        else $error("and gate result wrong");
    operand_pick_a: assert property ((i_operand_a_select == 4'h8)
        && (i_operand_b_select == 4'h8)
        && (i_gate_operator_select == tlas_pkg::OP_OR)
        |=> o_gate_result == $past(i_out_cond[8]))
        else $error("operand not taken from condition");
    term_log_a: assert property ((i_relay_func == tlas_pkg::FUNC_LOG)
        && (i_term11_func == tlas_pkg::FUNC_LOG)
        |=> (o_relay == o_gate_result) && (o_term11 == o_gate_result))
        else $error("terminal does not follow gate");
    volt_src_a: assert property (i_kind_sel_assigned && !i_input_kind_sel
        && nxt_freq_valid && (i_analog_input_config == tlas_pkg::CFG_VI)
        |=> o_freq_cmd == 11'($past(i_vin_sense)))
        else $error("voltage input not selected");
    curr_src_a: assert property (i_kind_sel_assigned && i_input_kind_sel
        && nxt_freq_valid && (i_analog_input_config == tlas_pkg::CFG_VI)
        |=> o_freq_cmd == 11'($past(i_iin_sense)))
        else $error("current input not selected");
    sum_src_a: assert property (!i_kind_sel_assigned && nxt_freq_valid
        |=> o_freq_cmd == 11'($past(i_vin_sense)) + 11'($past(i_iin_sense)))
        else $error("inputs not summed");
    src_gate_a: assert property (i_frequency_source_select != tlas_pkg::SRC_ANALOG
        |=> !o_freq_cmd_valid && (o_freq_cmd == 11'h000))
        else $error("analog command without analog source");
    pot_src_a: assert property (i_kind_sel_assigned && i_input_kind_sel
        && nxt_freq_valid && (i_analog_input_config == tlas_pkg::CFG_IPOT)
        |=> o_freq_cmd == 11'($past(i_keypad_pot)))
        else $error("keypad pot not selected");
    mon_range_a: assert property (o_monitor_output <= tlas_pkg::MON_FS)
        else $error("monitor above 10 V");
    curr_full_a: assert property ((i_monitor_quantity_select == tlas_pkg::QTY_CURR)
        && (i_out_current == tlas_pkg::IN_FS) && (gain_ff == tlas_pkg::GAIN_RST)
        && (offset_ff == 10'h000) |=> o_monitor_output == tlas_pkg::MON_FS)
        else $error("full current not full scale");
    // The default disable would hide this check, since it watches reset itself
    gain_init_a: assert property (@(posedge i_sys_clk) disable iff (1'b0)
        !i_rstn |=> o_monitor_gain == tlas_pkg::GAIN_RST)
        else $error("gain not 100 after reset");
    zero_offset_a: assert property ((i_monitor_quantity_select == tlas_pkg::QTY_FREQ)
        && (i_out_freq == 10'h000) |=> o_monitor_output == $past(offset_ff))
        else $error("zero speed level not offset");

    sum_cover_c:  cover property (!i_kind_sel_assigned && nxt_freq_valid ##1 o_freq_cmd_valid);
    xor_cover_c:  cover property ((i_gate_operator_select == tlas_pkg::OP_XOR) && opnd_a
                                  && opnd_b ##1 !o_gate_result);
    sat_cover_c:  cover property (o_monitor_output == tlas_pkg::MON_FS);
    gain_cover_c: cover property (i_monitor_gain_wr ##1 o_monitor_gain != tlas_pkg::GAIN_RST);
endmodule : tlas_top

// [tlas_top_tb.sv]
// Self-checking bench for the terminal logic and analog select block
`timescale 1ns/10ps
module tlas_top_tb;
    logic        i_sys_clk = 1'b0;
    logic        i_rstn = 1'b0;
    logic [8:0]  i_out_cond = 9'h000;
    logic [3:0]  opa = 4'h0, opb = 4'h0, t11 = 4'h0, t12 = 4'h0, rly = 4'h0;
    logic [1:0]  opsel = 2'h0, fsrc = 2'h0, cfg = 2'h0, qsel = 2'h0;
    logic        kind = 1'b0, asg = 1'b0, load = 1'b0, gwr = 1'b0, owr = 1'b0;
    logic [9:0]  vin = 10'h000, iin = 10'h000, pot = 10'h000, frq = 10'h000;
    logic [9:0]  cur = 10'h000, odat = 10'h000, off_sh = 10'h000;
    logic [7:0]  gdat = 8'h00, gain_sh = 8'h64;
    logic [9:0]  s_vin, s_iin, s_pot, o_monitor_offset, o_monitor_output;
    logic        o_gate_result, o_term11, o_term12, o_relay, o_freq_cmd_valid;
    logic [10:0] o_freq_cmd;
    logic [7:0]  o_monitor_gain;
    logic [43:0] exp_q[$];
    logic [31:0] seed = 32'h0000005D;
    int          fails = 0, total_checks = 0;

    // Clock of 5 ns
    always #2.5 i_sys_clk = ~i_sys_clk;

    tlas_field_model u_field (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_load(load),
        .i_vin(vin), .i_iin(iin), .i_pot(pot), .o_vin(s_vin), .o_iin(s_iin), .o_pot(s_pot));

    tlas_top u_dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_out_cond(i_out_cond),
        .i_operand_a_select(opa), .i_operand_b_select(opb), .i_gate_operator_select(opsel),
        .i_term11_func(t11), .i_term12_func(t12), .i_relay_func(rly),
        .i_input_kind_sel(kind), .i_kind_sel_assigned(asg), .i_frequency_source_select(fsrc),
        .i_analog_input_config(cfg), .i_vin_sense(s_vin), .i_iin_sense(s_iin),
        .i_keypad_pot(s_pot), .i_monitor_quantity_select(qsel), .i_out_freq(frq),
        .i_out_current(cur), .i_monitor_gain_wr(gwr), .i_monitor_gain(gdat),
        .i_monitor_offset_wr(owr), .i_monitor_offset(odat), .o_gate_result(o_gate_result),
        .o_term11(o_term11), .o_term12(o_term12), .o_relay(o_relay),
        .o_freq_cmd_valid(o_freq_cmd_valid), .o_freq_cmd(o_freq_cmd),
        .o_monitor_gain(o_monitor_gain), .o_monitor_offset(o_monitor_offset),
        .o_monitor_output(o_monitor_output));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Terminal state for a function code: gate result, a condition, or off
    function automatic logic term_of(input logic [3:0] f, input logic g);
        return (f == 4'h9) ? g : (f <= 4'h8) ? i_out_cond[f] : 1'b0;
    endfunction : term_of

    // Expected outputs from the bench's own view of the inputs
    function automatic logic [43:0] expect_all();
        logic        a, b, g;
        logic [10:0] cmd;
        logic [9:0]  q;
        logic [21:0] m;
        a = (opa <= 4'h8) ? i_out_cond[opa] : 1'b0;
        b = (opb <= 4'h8) ? i_out_cond[opb] : 1'b0;
        case (opsel)
            2'h0: g = a & b;
            2'h1: g = a | b;
            2'h2: g = a ^ b;
            default: g = 1'b0;
        endcase
        if (fsrc != 2'h1) cmd = 11'h000;
        else if (!asg || cfg == 2'h1) cmd = {1'b0, vin} + {1'b0, iin};
        else if (cfg == 2'h0) cmd = {1'b0, kind ? iin : vin};
        else if (cfg == 2'h2) cmd = {1'b0, kind ? pot : vin};
        else cmd = {1'b0, kind ? pot : iin};
        q = (qsel == 2'h0) ? frq : (qsel == 2'h1) ? cur : 10'h000;
        m = {12'h000, off_sh} + ({12'h000, q} * {14'h0000, gain_sh} * 22'h00000A) / 22'h0003FF;
        m = (m > 22'h0003E8) ? 22'h0003E8 : m;
        return {g, term_of(t11, g), term_of(t12, g), term_of(rly, g), (fsrc == 2'h1), cmd,
                gain_sh, off_sh, m[9:0]};
    endfunction : expect_all

    task automatic wrap_up();
        if (fails == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Mode 0 no writes, 1 random writes, 2 gain and offset at maximum with zero
    // frequency shown, 3 directed gate, terminal and full-current picks, no writes
    task automatic step(input logic [1:0] mode);
        logic [31:0] r1, r2, r3, r4;
        logic        gw, ow;
        r1 = rnd();
        r2 = rnd();
        r3 = rnd();
        r4 = rnd();
        // Directed fields so the rarer checks see their trigger
        if (mode == 2'h3) begin
            r1[30:9] = {4'h9, r1[26:23], 4'h9, 2'h1, 8'h88};
            r2[26:25] = 2'h1;
            r4[29:20] = 10'h3FF;
        end
        if (mode == 2'h2) begin
            r2[26:25] = 2'h0;
            r4[19:10] = 10'h000;
        end
        gw = (mode == 2'h2) || (mode == 2'h1 && r3[1:0] == 2'h0);
        ow = (mode == 2'h2) || (mode == 2'h1 && r3[11:10] == 2'h0);
        @(posedge i_sys_clk);
        {kind, rly, t12, t11, opsel, opb, opa, i_out_cond} <= r1;
        {qsel, iin, vin, cfg, fsrc, asg} <= r2[26:0];
        {cur, frq, pot} <= r4[29:0];
        gdat <= (mode == 2'h2) ? 8'hFF : r3[9:2];
        odat <= (mode == 2'h2) ? 10'h3FF : r3[21:12];
        gwr <= gw;
        owr <= ow;
        load <= 1'b1;
        @(posedge i_sys_clk);
        gwr <= 1'b0;
        owr <= 1'b0;
        load <= 1'b0;
        if (gw) gain_sh = gdat;
        if (ow) off_sh = (odat > 10'h3E8) ? 10'h3E8 : odat;
        @(posedge i_sys_clk);
        exp_q.push_back(expect_all());
    endtask : step

    // Watcher: compares the oldest note once its result has settled
    always @(negedge i_sys_clk) begin
        if (exp_q.size() > 0) begin
            automatic logic [43:0] e = exp_q.pop_front();
            chk({10'h000, o_gate_result}, {10'h000, e[43]}, "gate");
            chk({8'h00, o_term11, o_term12, o_relay}, {8'h00, e[42:40]}, "terminals");
            chk({10'h000, o_freq_cmd_valid}, {10'h000, e[39]}, "source valid");
            chk(o_freq_cmd, e[38:28], "freq command");
            chk({3'h0, o_monitor_gain}, {3'h0, e[27:20]}, "gain");
            chk({1'b0, o_monitor_offset}, {1'b0, e[19:10]}, "offset");
            chk({1'b0, o_monitor_output}, {1'b0, e[9:0]}, "monitor");
        end
    end

    // Hang guard well above the roughly 1230 cycles the sequence takes
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        fails++;
        wrap_up();
    end

    // Main sequence: defaults, saturating writes, random traffic, second reset
    initial begin
        repeat (16) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        step(2'h3);
        step(2'h2);
        for (int n = 0; n < 400; n++) begin
            step(2'h1);
        end
        @(posedge i_sys_clk);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        gain_sh = 8'h64;
        off_sh = 10'h000;
        step(2'h0);
        for (int w = 0; w < 10 && exp_q.size() > 0; w++) begin
            @(posedge i_sys_clk);
        end
        if (exp_q.size() > 0) fails++;
        wrap_up();
    end
endmodule : tlas_top_tb
